// ==== smc_cfg_if.sv ====
// Purpose: Carries the live monitor settings from register side to sampler.
// Assumes: Single clock domain.
// Notes: Settings here are already synchronised.
`timescale 1ns/1ps
`default_nettype none
interface smc_cfg_if;
   logic enable;
   logic sampled;
   logic clk_on;
   logic [3:0] psel;
   logic [1:0] action;
   logic clk_stable;
   logic below_evt;
   modport ctrl (output enable, output sampled, output clk_on, output psel, output action,
      input clk_stable, input below_evt);
   modport mon (input enable, input sampled, input clk_on, input psel, input action,
      output clk_stable, output below_evt);
endinterface : smc_cfg_if
`default_nettype wire

// ==== smc_pkg.sv ====
// Purpose: Shared constants and types for the supply monitor control registers.
// Assumes: 32-bit Avalon-MM register bus, 100 MHz mclk.
// Notes: Offsets are byte addresses.
package smc_pkg;
   localparam logic [7:0] SMC_OFF_MON = 8'h34;
   localparam logic [7:0] SMC_OFF_REG = 8'h3c;
   localparam logic [7:0] SMC_OFF_REF = 8'h40;
   localparam logic [7:0] SMC_OFF_WP = 8'h00;
   localparam int SMC_LVL_LO = 16;
   localparam int SMC_LVL_W = 6;
   localparam int SMC_PSEL_LO = 12;
   localparam int SMC_PSEL_W = 4;
   localparam int SMC_CEN_BIT = 9;
   localparam int SMC_MODE_BIT = 8;
   localparam int SMC_STBY_BIT = 6;
   localparam int SMC_ACT_LO = 3;
   localparam int SMC_THRESHOLD_HYSTERESIS_BIT = 2;
   localparam int SMC_EN_BIT = 1;
   localparam int SMC_HDRV_BIT = 13;
   localparam int SMC_RSTBY_BIT = 6;
   localparam int SMC_TRIM_LO = 16;
   localparam int SMC_TRIM_W = 11;
   localparam int SMC_BGADC_BIT = 2;
   localparam logic [1:0] SMC_ACT_NONE = 2'h0;
   localparam logic [1:0] SMC_ACT_RESET = 2'h1;
   localparam logic [1:0] SMC_ACT_IRQ = 2'h2;
   localparam int SMC_CLK_HZ = 100000000;
   localparam int SMC_ULP_HZ = 1000;
   localparam int SMC_ULP_DIV = SMC_CLK_HZ / SMC_ULP_HZ;
   localparam int SMC_SYNC_STAGES = 2;
   localparam logic [31:0] SMC_WP_KEY_OFF = 32'h0000_0000;
   localparam logic [31:0] SMC_BUS_ZERO = 32'h0000_0000;
endpackage : smc_pkg

// ==== smc_regs.sv ====
// Purpose: Supply monitor, regulator and reference control registers.
// Assumes: Avalon-MM slave, one wait cycle on every access.
// Notes: Flash-loaded fields are captured from strap inputs after reset release.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Threshold level field at bits 21:16.
// - Level, action, hysteresis, enable load from flash.
// - Prescaler divides by two to (code+1).
// - Prescaler input is 1 kHz oscillator.
// - Sample clock enable bit starts/stops clock.
// - Sample clock enable bit reads actual clock stability.
// - Mode bit selects continuous or sampled.
// - Standby bit keeps monitor in standby.
// - Action field selects none, reset, interrupt.
// - Hysteresis bit enables threshold hysteresis.
// - Enable bit turns detector on.
// - Monitor register write-protected and synchronised.
// - Force bit selects standby high drive.
// - Regulator standby bit keeps normal configuration.
// - Eleven-bit trim loaded from calibration flash.
// - Output enable routes bandgap to ADC.
module smc_regs
   import smc_pkg::*;
#(
   parameter int ULP_DIV = SMC_ULP_DIV
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic avs_response_err,
   input wire logic [5:0] flash_level,
   input wire logic [1:0] flash_action,
   input wire logic flash_threshold_hysteresis,
   input wire logic flash_enable,
   input wire logic [10:0] flash_trim,
   input wire logic in_standby,
   input wire logic below_thr,
   output logic mon_active,
   output logic [5:0] mon_level,
   output logic mon_threshold_hysteresis,
   output logic mon_reset_req,
   output logic mon_irq,
   output logic standby_high_drive,
   output logic regulator_normal_stby,
   output logic [10:0] bandgap_trim,
   output logic bandgap_to_adc
);
   typedef struct packed {
      logic loaded;
      logic wp;
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic [5:0] level;
      logic [3:0] psel;
      logic clk_on;
      logic sampled;
      logic keep_in_standby;
      logic [1:0] action;
      logic threshold_hysteresis;
      logic enable;
      logic [SMC_SYNC_STAGES-1:0] wr_pipe;
      logic [31:0] shadow;
      logic high_drive;
      logic reg_stby;
      logic [10:0] trim;
      logic bg_adc;
      logic [16:0] ulp_cnt;
      logic ulp_tick;
      logic rst_req;
      logic irq;
   } smc_regs_t;
   smc_regs_t s_r;
   smc_regs_t s_nxt;
   smc_cfg_if cfg ();
   logic req;
   logic wr_ok;
   logic [31:0] wmask;
   logic [31:0] merged;
   logic [31:0] mon_word;
   logic [16:0] ulp_lim;
   logic [5:0] shadow_level;
   logic [3:0] shadow_psel;
   assign ulp_lim = 17'(ULP_DIV - 1);
   // Fields of the pending monitor write, watched by the crossing assertions below.
   assign shadow_level = s_r.shadow[SMC_LVL_LO +: SMC_LVL_W];
   assign shadow_psel = s_r.shadow[SMC_PSEL_LO +: SMC_PSEL_W];
   assign req = (avs_read || avs_write) && !s_r.ack;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
      end
      mon_word = SMC_BUS_ZERO;
      mon_word[SMC_LVL_LO +: SMC_LVL_W] = s_r.level;
      mon_word[SMC_PSEL_LO +: SMC_PSEL_W] = s_r.psel;
      mon_word[SMC_CEN_BIT] = cfg.clk_stable;
      mon_word[SMC_MODE_BIT] = s_r.sampled;
      mon_word[SMC_STBY_BIT] = s_r.keep_in_standby;
      mon_word[SMC_ACT_LO +: 2] = s_r.action;
      mon_word[SMC_THRESHOLD_HYSTERESIS_BIT] = s_r.threshold_hysteresis;
      mon_word[SMC_EN_BIT] = s_r.enable;
   end
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = req;
      s_nxt.err = 1'b0;
      s_nxt.ulp_tick = 1'b0;
      s_nxt.rst_req = 1'b0;
      wr_ok = 1'b0;
      merged = SMC_BUS_ZERO;
      s_nxt.wr_pipe = {s_r.wr_pipe[SMC_SYNC_STAGES-2:0], 1'b0};
      // Flash straps are caught one cycle after reset release, never under reset.
      if (!s_r.loaded) begin
         s_nxt.loaded = 1'b1;
         s_nxt.level = flash_level;
         s_nxt.action = flash_action;
         s_nxt.threshold_hysteresis = flash_threshold_hysteresis;
         s_nxt.enable = flash_enable;
         s_nxt.trim = flash_trim;
      end
      if (s_r.ulp_cnt >= ulp_lim) begin
         s_nxt.ulp_cnt = '0;
         s_nxt.ulp_tick = 1'b1;
      end else begin
         s_nxt.ulp_cnt = s_r.ulp_cnt + 17'h00001;
      end
      if (req && avs_write) begin
         wr_ok = !s_r.wp;
         unique case (avs_address)
            SMC_OFF_WP: begin
               s_nxt.wp = avs_writedata[0];
            end
            SMC_OFF_MON: begin
               merged = (avs_writedata & wmask) | (mon_word & ~wmask);
               if (wr_ok) begin
                  s_nxt.shadow = merged;
                  s_nxt.wr_pipe[0] = 1'b1;
               end
            end
            SMC_OFF_REG: begin
               if (wr_ok) begin
                  if (avs_byteenable[1]) begin
                     s_nxt.high_drive = avs_writedata[SMC_HDRV_BIT];
                  end
                  if (avs_byteenable[0]) begin
                     s_nxt.reg_stby = avs_writedata[SMC_RSTBY_BIT];
                  end
               end
            end
            SMC_OFF_REF: begin
               if (wr_ok) begin
                  merged = (avs_writedata & wmask);
                  if (avs_byteenable[2] && avs_byteenable[3]) begin
                     s_nxt.trim = merged[SMC_TRIM_LO +: SMC_TRIM_W];
                  end
                  if (avs_byteenable[0]) begin
                     s_nxt.bg_adc = avs_writedata[SMC_BGADC_BIT];
                  end
               end
            end
            default: s_nxt.err = 1'b1;
         endcase
      end
      // The synchronised copy takes effect only after the write has crossed over.
      if (s_r.wr_pipe[SMC_SYNC_STAGES-1]) begin
         s_nxt.level = s_r.shadow[SMC_LVL_LO +: SMC_LVL_W];
         s_nxt.psel = s_r.shadow[SMC_PSEL_LO +: SMC_PSEL_W];
         s_nxt.clk_on = s_r.shadow[SMC_CEN_BIT];
         s_nxt.sampled = s_r.shadow[SMC_MODE_BIT];
         s_nxt.keep_in_standby = s_r.shadow[SMC_STBY_BIT];
         s_nxt.action = s_r.shadow[SMC_ACT_LO +: 2];
         s_nxt.threshold_hysteresis = s_r.shadow[SMC_THRESHOLD_HYSTERESIS_BIT];
         s_nxt.enable = s_r.shadow[SMC_EN_BIT];
      end
      if (req && avs_read) begin
         unique case (avs_address)
            SMC_OFF_WP: s_nxt.rdata = {31'h00000000, s_r.wp};
            SMC_OFF_MON: s_nxt.rdata = mon_word;
            SMC_OFF_REG: begin
               s_nxt.rdata = SMC_BUS_ZERO;
               s_nxt.rdata[SMC_HDRV_BIT] = s_r.high_drive;
               s_nxt.rdata[SMC_RSTBY_BIT] = s_r.reg_stby;
            end
            SMC_OFF_REF: begin
               s_nxt.rdata = SMC_BUS_ZERO;
               s_nxt.rdata[SMC_TRIM_LO +: SMC_TRIM_W] = s_r.trim;
               s_nxt.rdata[SMC_BGADC_BIT] = s_r.bg_adc;
            end
            default: begin
               s_nxt.rdata = SMC_BUS_ZERO;
               s_nxt.err = 1'b1;
            end
         endcase
      end
      // Reserved action code 3 does nothing, like code 0.
      if (cfg.below_evt && mon_active) begin
         s_nxt.rst_req = (s_r.action == SMC_ACT_RESET);
         s_nxt.irq = (s_r.action == SMC_ACT_IRQ);
      end else begin
         s_nxt.irq = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign cfg.enable = mon_active;
   assign cfg.sampled = s_r.sampled;
   assign cfg.clk_on = s_r.clk_on;
   assign cfg.psel = s_r.psel;
   assign cfg.action = s_r.action;
   assign mon_active = s_r.enable && (!in_standby || s_r.keep_in_standby);
   assign mon_level = s_r.level;
   assign mon_threshold_hysteresis = s_r.threshold_hysteresis;
   assign mon_reset_req = s_r.rst_req;
   assign mon_irq = s_r.irq;
   assign standby_high_drive = s_r.high_drive;
   assign regulator_normal_stby = s_r.reg_stby;
   assign bandgap_trim = s_r.trim;
   assign bandgap_to_adc = s_r.bg_adc;
   assign avs_waitrequest = !s_r.ack;
   assign avs_readdata = s_r.rdata;
   assign avs_response_err = s_r.err;
   smc_sampler u_smc_sampler (
      .mclk(mclk),
      .reset(reset),
      .ulp_tick(s_r.ulp_tick),
      .below_thr(below_thr),
      .cfg(cfg)
   );
   wp_block_a: assert property (@(posedge mclk) disable iff (reset)
      (req && avs_write && s_r.wp && avs_address == SMC_OFF_REF) |=> $stable(bandgap_trim))
      else $error("protected write changed trim");
   sync_delay_a: assert property (@(posedge mclk) disable iff (reset)
      (req && avs_write && !s_r.wp && avs_address == SMC_OFF_MON && s_r.loaded
       && !s_r.wr_pipe[0] && !s_r.wr_pipe[SMC_SYNC_STAGES-1] && !s_r.enable)
      |=> !s_r.enable) else $error("monitor write took effect early");
   act_reset_a: assert property (@(posedge mclk) disable iff (reset)
      mon_reset_req |-> $past(s_r.action) == SMC_ACT_RESET)
      else $error("reset without reset action");
   act_irq_a: assert property (@(posedge mclk) disable iff (reset)
      mon_irq |-> $past(s_r.action) == SMC_ACT_IRQ && $past(cfg.below_evt))
      else $error("interrupt without cause");
   // Checked on the actions, since the active flag itself is a plain product of its terms.
   stby_off_a: assert property (@(posedge mclk) disable iff (reset)
      (in_standby && !s_r.keep_in_standby) |=> !mon_irq && !mon_reset_req)
      else $error("monitor acted in standby");
   bus_wait_a: assert property (@(posedge mclk) disable iff (reset)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("slave did not answer in one cycle");
   reg_drive_a: assert property (@(posedge mclk) disable iff (reset)
      (req && avs_write && !s_r.wp && avs_address == SMC_OFF_REG && avs_byteenable[1])
      |=> standby_high_drive == $past(avs_writedata[SMC_HDRV_BIT]))
      else $error("high drive bit not written");
   bg_route_a: assert property (@(posedge mclk) disable iff (reset)
      (req && avs_write && !s_r.wp && avs_address == SMC_OFF_REF && avs_byteenable[0])
      |=> bandgap_to_adc == $past(avs_writedata[SMC_BGADC_BIT]))
      else $error("bandgap route bit not written");
   // Straps land at the first edge after reset release.
   strap_load_a: assert property (@(posedge mclk) disable iff (reset)
      !s_r.loaded |=> mon_level == $past(flash_level) && bandgap_trim == $past(flash_trim)
      && mon_threshold_hysteresis == $past(flash_threshold_hysteresis))
      else $error("straps not loaded");
   sync_level_a: assert property (@(posedge mclk) disable iff (reset)
      s_r.wr_pipe[SMC_SYNC_STAGES-1] |=> mon_level == $past(shadow_level))
      else $error("level not applied after crossing");
   sync_psel_a: assert property (@(posedge mclk) disable iff (reset)
      s_r.wr_pipe[SMC_SYNC_STAGES-1] |=> cfg.psel == $past(shadow_psel))
      else $error("prescaler not applied after crossing");
   wp_reg_a: assert property (@(posedge mclk) disable iff (reset)
      (req && avs_write && s_r.wp && avs_address == SMC_OFF_REG)
      |=> $stable(standby_high_drive) && $stable(regulator_normal_stby))
      else $error("protected write changed regulator");
   wp_mon_a: assert property (@(posedge mclk) disable iff (reset)
      (req && avs_write && s_r.wp && avs_address == SMC_OFF_MON) |=> !s_r.wr_pipe[0])
      else $error("protected write entered the crossing");
   // A partial trim write would leave a trim that no flash row ever held.
   trim_pair_a: assert property (@(posedge mclk) disable iff (reset)
      (req && avs_write && !s_r.wp && avs_address == SMC_OFF_REF && s_r.loaded
       && !(avs_byteenable[2] && avs_byteenable[3])) |=> $stable(bandgap_trim))
      else $error("trim changed by partial write");
   act_none_a: assert property (@(posedge mclk) disable iff (reset)
      (s_r.action == SMC_ACT_NONE) |=> !mon_reset_req && !mon_irq)
      else $error("action raised with no action set");
   off_quiet_a: assert property (@(posedge mclk) disable iff (reset)
      !mon_active |=> !mon_reset_req && !mon_irq)
      else $error("action raised while monitor off");
endmodule : smc_regs
`default_nettype wire

// ==== smc_sampler.sv ====
// Purpose: Prescaled sampling of the threshold comparator.
// Assumes: ulp_tick is a one-cycle pulse at the 1 kHz rate.
// Notes: Sample clock runs only while clk_on is set.
`timescale 1ns/1ps
`default_nettype none
module smc_sampler
   import smc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ulp_tick,
   input wire logic below_thr,
   smc_cfg_if.mon cfg
);
   typedef struct packed {
      logic [15:0] cnt;
      logic stable;
      logic evt;
   } smc_smp_t;
   smc_smp_t s_r;
   smc_smp_t s_nxt;
   logic smp_tick;
   logic [15:0] lim;
   always_comb begin
      lim = 16'((32'h2 << cfg.psel) - 32'h1);
      smp_tick = 1'b0;
      s_nxt = s_r;
      s_nxt.evt = 1'b0;
      if (cfg.clk_on && ulp_tick) begin
         s_nxt.stable = 1'b1;
         if (s_r.cnt >= lim) begin
            s_nxt.cnt = 16'h0000;
            smp_tick = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
         end
      end else if (!cfg.clk_on && ulp_tick) begin
         s_nxt.stable = 1'b0;
         s_nxt.cnt = 16'h0000;
      end
      if (cfg.enable) begin
         if (cfg.sampled) begin
            s_nxt.evt = smp_tick && s_r.stable && below_thr;
         end else begin
            s_nxt.evt = below_thr;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign cfg.clk_stable = s_r.stable;
   assign cfg.below_evt = s_r.evt;
   off_no_evt_a: assert property (@(posedge mclk) disable iff (reset)
      !cfg.enable |=> !cfg.below_evt) else $error("event while monitor off");
   smp_evt_a: assert property (@(posedge mclk) disable iff (reset)
      (cfg.enable && cfg.sampled && !smp_tick) |=> !cfg.below_evt)
      else $error("sampled event without sample tick");
   cont_evt_a: assert property (@(posedge mclk) disable iff (reset)
      (cfg.enable && !cfg.sampled && below_thr) |=> cfg.below_evt)
      else $error("continuous mode missed a low supply");
   clk_start_a: assert property (@(posedge mclk) disable iff (reset)
      (cfg.clk_on && ulp_tick) |=> cfg.clk_stable)
      else $error("sample clock did not start");
   clk_stop_a: assert property (@(posedge mclk) disable iff (reset)
      (!cfg.clk_on && ulp_tick) |=> !cfg.clk_stable)
      else $error("sample clock did not stop");
endmodule : smc_sampler
`default_nettype wire

// ==== test_supply_monitor_ctrl_regs.sv ====
// Purpose: Self-checking bench for the supply monitor control registers.
// Assumes: One wait cycle per bus access, ULP_DIV shortened to 4 cycles a tick.
// Notes: Checks straps, register fields, protection, actions and sampled pacing.
`timescale 1ns/1ps
`default_nettype none
module test_supply_monitor_ctrl_regs;
   import smc_pkg::*;
   localparam int DIV = 4;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic avs_response_err;
   logic in_standby = 1'b0;
   logic below_thr = 1'b0;
   logic mon_active, mon_threshold_hysteresis, mon_reset_req, mon_irq;
   logic standby_high_drive, regulator_normal_stby, bandgap_to_adc;
   logic [5:0] mon_level;
   logic [10:0] bandgap_trim;
   logic [31:0] q;
   logic e;
   int mismatches = 0;
   int n_checks = 0;
   int c;

   always #5 mclk = ~mclk;

   smc_regs #(.ULP_DIV(DIV)) u_smc_regs (
      .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response_err(avs_response_err), .flash_level(6'h2a), .flash_action(2'h1),
      .flash_threshold_hysteresis(1'b1), .flash_enable(1'b1), .flash_trim(11'h5a3), .in_standby(in_standby),
      .below_thr(below_thr), .mon_active(mon_active), .mon_level(mon_level),
      .mon_threshold_hysteresis(mon_threshold_hysteresis), .mon_reset_req(mon_reset_req), .mon_irq(mon_irq),
      .standby_high_drive(standby_high_drive), .regulator_normal_stby(regulator_normal_stby),
      .bandgap_trim(bandgap_trim), .bandgap_to_adc(bandgap_to_adc)
   );

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One edge passes first so a release and a new request never share a time step.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         mismatches++;
      end
      q = avs_readdata;
      e = avs_response_err;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, exp);
      chk({31'h0, e}, 32'h0000_0000);
   endtask : rd

   function automatic logic [31:0] mw(input logic [3:0] ps, input logic sample_clock_on, input logic md,
         input logic sb, input logic [1:0] act, input logic hy, input logic en);
      return {10'h000, 6'h2a, ps, 2'b00, sample_clock_on, md, 1'b0, sb, 1'b0, act, hy, en, 1'b0};
   endfunction : mw

   task automatic count_irq();
      c = 0;
      repeat (160) begin
         @(posedge mclk);
         if (mon_irq === 1'b1) begin
            c++;
         end
      end
   endtask : count_irq

   initial begin
      #100000;
      mismatches++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      rd(SMC_OFF_MON, 32'h002a_000e);
      rd(SMC_OFF_REF, 32'h05a3_0000);
      rd(SMC_OFF_REG, 32'h0000_0000);
      chk({14'h0, mon_level, bandgap_trim, mon_threshold_hysteresis}, {14'h0, 6'h2a, 11'h5a3, 1'b1});
      bus(1'b1, SMC_OFF_REG, 32'h0000_2040);
      rd(SMC_OFF_REG, 32'h0000_2040);
      chk({30'h0, standby_high_drive, regulator_normal_stby}, 32'h0000_0003);
      bus(1'b1, SMC_OFF_REG, 32'h0000_2000);
      rd(SMC_OFF_REG, 32'h0000_2000);
      chk({30'h0, standby_high_drive, regulator_normal_stby}, 32'h0000_0002);
      bus(1'b1, SMC_OFF_REF, 32'h03ff_0004);
      rd(SMC_OFF_REF, 32'h03ff_0004);
      chk({20'h0, bandgap_trim, bandgap_to_adc}, 32'h0000_07ff);
      // Protected writes must leave every stored field alone.
      bus(1'b1, SMC_OFF_WP, 32'h0000_0001);
      bus(1'b1, SMC_OFF_REG, 32'h0000_0000);
      bus(1'b1, SMC_OFF_REF, 32'h0000_0000);
      bus(1'b1, SMC_OFF_MON, 32'h0000_0000);
      rd(SMC_OFF_REG, 32'h0000_2000);
      rd(SMC_OFF_REF, 32'h03ff_0004);
      rd(SMC_OFF_MON, 32'h002a_000e);
      bus(1'b1, SMC_OFF_WP, 32'h0000_0000);
      bus(1'b0, 8'h20, 32'h0000_0000);
      chk({e, q[30:0]}, 32'h8000_0000);
      // Bytes 0 and 2 only: the trim must hold, the route bit must follow byte 0.
      avs_byteenable <= 4'h5;
      bus(1'b1, SMC_OFF_REF, 32'h0000_0000);
      avs_byteenable <= 4'hf;
      rd(SMC_OFF_REF, 32'h03ff_0000);
      in_standby <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({31'h0, mon_active}, 32'h0000_0000);
      bus(1'b1, SMC_OFF_MON, mw(4'h0, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1));
      repeat (4) @(posedge mclk);
      chk({31'h0, mon_active}, 32'h0000_0001);
      in_standby <= 1'b0;
      below_thr <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         bus(1'b1, SMC_OFF_MON, mw(4'h0, 1'b0, 1'b0, 1'b0, a[1:0], 1'b1, 1'b1));
         repeat (10) @(posedge mclk);
         chk({30'h0, mon_reset_req, mon_irq}, (a == 1) ? 32'h2 : (a == 2) ? 32'h1 : 32'h0);
      end
      bus(1'b1, SMC_OFF_MON, mw(4'h0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b1, 1'b1));
      repeat (4) @(posedge mclk);
      count_irq();
      chk(c, 160);
      // Sampled mode: psel 0 samples every 2 ticks, psel 1 every 4 ticks.
      bus(1'b1, SMC_OFF_MON, mw(4'h0, 1'b1, 1'b1, 1'b0, 2'h2, 1'b1, 1'b1));
      repeat (40) @(posedge mclk);
      rd(SMC_OFF_MON, mw(4'h0, 1'b1, 1'b1, 1'b0, 2'h2, 1'b1, 1'b1));
      count_irq();
      chk({31'h0, c >= 19 && c <= 21}, 32'h1);
      bus(1'b1, SMC_OFF_MON, mw(4'h1, 1'b1, 1'b1, 1'b0, 2'h2, 1'b1, 1'b1));
      repeat (40) @(posedge mclk);
      count_irq();
      chk({31'h0, c >= 9 && c <= 11}, 32'h1);
      below_thr <= 1'b0;
      repeat (4) @(posedge mclk);
      count_irq();
      chk(c, 0);
      bus(1'b1, SMC_OFF_MON, mw(4'h0, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0));
      below_thr <= 1'b1;
      repeat (40) @(posedge mclk);
      rd(SMC_OFF_MON, mw(4'h0, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0));
      chk({29'h0, mon_reset_req, mon_threshold_hysteresis, mon_active}, 32'h0000_0000);
      // The monitor is off here, so the level may be changed safely.
      bus(1'b1, SMC_OFF_MON, 32'h0015_0000);
      repeat (4) @(posedge mclk);
      chk({26'h0, mon_level}, 32'h0000_0015);
      stop_test();
   end
endmodule : test_supply_monitor_ctrl_regs
`default_nettype wire
